/* sim/preset_speed_command_selector_bench.sv */
// Purpose: self-checking bench for the preset speed command selector
// Assumes: register port answers reads one cycle after the strobe
// Notes: a second instance without analog input shares the bus
`timescale 1ns/1ps
`include "pss_cfg.svh"
module preset_speed_command_selector_bench;
    logic clock, sys_rst, reg_wr, reg_rd;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, analog_speed_channel;
    logic [15:0] reg_rdata, speed_command, rdata2, cmd2;
    logic [2:0] running_index, index2;
    logic source_is_analog, src2, s0, s1, s2;
    int n_mismatch, num_checks;

    pss_host_model host (.clock(clock), .preset_select_bit0(s0),
        .preset_select_bit1(s1), .preset_select_bit2(s2));
    pss_selector uut (.clock(clock), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .preset_select_bit0(s0),
        .preset_select_bit1(s1), .preset_select_bit2(s2),
        .analog_speed_channel(analog_speed_channel),
        .speed_command(speed_command), .running_index(running_index),
        .source_is_analog(source_is_analog));
    pss_selector #(.HAS_ANALOG(1'b0)) uut2 (.clock(clock), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(rdata2), .preset_select_bit0(s0),
        .preset_select_bit1(s1), .preset_select_bit2(s2),
        .analog_speed_channel(analog_speed_channel),
        .speed_command(cmd2), .running_index(index2),
        .source_is_analog(src2));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // ----------------------------------------
    // bus, compare and report tasks
    // ----------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // distinct preset values, one negative at the range limit
    function automatic logic [15:0] pv(input int i);
        return (i == 5) ? 16'hec78 : 16'(16'h0064 * (i + 1));
    endfunction

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [15:0] d;
        rd(`PSS_OFS_SOURCE, d);
        chk(d, 16'h0001, "source reset");
        chk(rdata2, 16'h0000, "variant source reset");
        chk({15'h0, source_is_analog}, 16'h0001, "analog flag");
        for (int i = 0; i < 8; i++) begin
            rd(`PSS_OFS_PRESET_BASE + 4'(i), d);
            chk(d, 16'h0000, "preset reset");
        end
    endtask

    task automatic t_presets();
        logic [15:0] d;
        wr(`PSS_OFS_SOURCE, 16'h0000);
        wr(`PSS_OFS_PRESET_BASE, 16'h1770);
        rd(`PSS_OFS_PRESET_BASE, d);
        chk(d, 16'h1388, "clamp high");
        wr(`PSS_OFS_PRESET_BASE, 16'he890);
        rd(`PSS_OFS_PRESET_BASE, d);
        chk(d, 16'hec78, "clamp low");
        for (int i = 0; i < 8; i++) wr(`PSS_OFS_PRESET_BASE + 4'(i), pv(i));
        for (int i = 0; i < 8; i++) begin
            rd(`PSS_OFS_PRESET_BASE + 4'(i), d);
            chk(d, pv(i), "preset readback");
        end
    endtask

    task automatic t_select();
        int n;
        for (int c = 0; c < 8; c++) begin
            host.drive(3'(c));
            #1 n = 0;
            while (running_index !== 3'(c) && n < 8) begin
                @(posedge clock);
                #1 n++;
            end
            if (running_index !== 3'(c)) begin
                n_mismatch++;
                results();
            end
            chk({13'h0, running_index}, 16'(c), "index");
            chk(speed_command, pv(c), "command");
            chk({13'h0, index2}, 16'(c), "variant index");
            chk(cmd2, pv(c), "variant command");
        end
    endtask

    task automatic t_update();
        wr(`PSS_OFS_PRESET_LAST, 16'h0123);
        @(posedge clock);
        #1 chk(speed_command, 16'h0123, "live preset");
    endtask

    task automatic t_analog();
        logic [15:0] d;
        analog_speed_channel <= 16'hfc18;
        wr(`PSS_OFS_SOURCE, 16'h0001);
        repeat (2) @(posedge clock);
        #1 chk(speed_command, 16'hfc18, "analog command");
        chk({15'h0, source_is_analog}, 16'h0001, "analog on");
        chk({15'h0, src2}, 16'h0000, "variant source");
        chk(cmd2, 16'h0123, "variant command");
        rd(`PSS_OFS_STATUS, d);
        chk(d, 16'h0007, "status read");
        rd(`PSS_OFS_COMMAND, d);
        chk(d, 16'hfc18, "command read");
        chk(rdata2, 16'h0123, "variant command read");
        rd(4'hb, d);
        chk(d, 16'h0000, "unmapped read");
    endtask

    task automatic t_midreset();
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        #1 chk(speed_command, 16'h0000, "command reset");
        chk({13'h0, running_index}, 16'h0000, "index reset");
        chk(cmd2, 16'h0000, "variant command reset");
        t_reset();
    endtask

    initial begin
        n_mismatch = 0;
        num_checks = 0;
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        analog_speed_channel = 16'h0000;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        t_reset();
        t_presets();
        t_select();
        t_update();
        t_analog();
        t_midreset();
        results();
    end
endmodule

/* sim/pss_host_model.sv */
// Purpose: host controller model driving the three preset select pins
// Assumes: pins are plain levels, changed just after a rising edge
// Notes: holds each code until told otherwise, like a real terminal
`timescale 1ns/1ps
module pss_host_model (
    input wire logic clock,
    output logic preset_select_bit0,
    output logic preset_select_bit1,
    output logic preset_select_bit2
);
    initial begin
        {preset_select_bit2, preset_select_bit1, preset_select_bit0} = 3'h0;
    end

    // terminals mapped to select bits 0..2, third select as msb
    task automatic drive(input logic [2:0] code);
        @(posedge clock);
        preset_select_bit0 <= code[0];
        preset_select_bit1 <= code[1];
        preset_select_bit2 <= code[2];
    endtask
endmodule

/* src/pss_cfg.svh */
// Purpose: constants for the preset speed command selector
// Assumes: register port with 4-bit word addresses, 16-bit data
// Notes: offsets are word indices on the plain register port
`ifndef PSS_CFG_SVH
`define PSS_CFG_SVH

`define PSS_ADDR_W 4
`define PSS_DATA_W 16
`define PSS_OFS_SOURCE 4'h0
`define PSS_OFS_PRESET_BASE 4'h1
`define PSS_OFS_PRESET_LAST 4'h8
`define PSS_OFS_STATUS 4'h9
`define PSS_OFS_COMMAND 4'ha
`define PSS_SOURCE_RESET 1'h1
`define PSS_SPEED_MAX 16'sd5000
`define PSS_SPEED_MIN (-16'sd5000)
`define PSS_PRESET_RESET 16'h0000
`define PSS_NUM_PRESETS 8
`define PSS_SEL_W 3

`endif

/* src/pss_pkg.sv */
// Purpose: shared types for the preset speed command selector
// Assumes: nothing
// Notes: source encoding follows the source-select register value
package pss_pkg;
    typedef enum logic {
        PSS_SRC_PRESET,
        PSS_SRC_ANALOG
    } pss_source_t;
endpackage

/* src/pss_preset_bank.sv */
// Purpose: eight signed preset speeds held in flip-flops
// Assumes: writes already address-decoded, one preset at a time
// Notes: out-of-range writes are clamped to the legal speed range
`timescale 1ns/1ps
`include "pss_cfg.svh"
module pss_preset_bank #(
    parameter int NUM = `PSS_NUM_PRESETS,
    parameter int IW = `PSS_SEL_W
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [IW-1:0] wr_idx,
    input wire logic [`PSS_DATA_W-1:0] wr_data,
    input wire logic [IW-1:0] rd_idx_a,
    input wire logic [IW-1:0] rd_idx_b,
    output logic [`PSS_DATA_W-1:0] rd_data_a,
    output logic [`PSS_DATA_W-1:0] rd_data_b
);
    logic [`PSS_DATA_W-1:0] preset_q [NUM];
    logic [`PSS_DATA_W-1:0] preset_d [NUM];
    logic signed [`PSS_DATA_W-1:0] clamped;

    // clamp keeps stored presets inside +-5000 rpm
    always_comb begin
        clamped = $signed(wr_data);
        if ($signed(wr_data) > `PSS_SPEED_MAX) begin
            clamped = `PSS_SPEED_MAX;
        end else if ($signed(wr_data) < `PSS_SPEED_MIN) begin
            clamped = `PSS_SPEED_MIN;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM; g++) begin : g_preset
            always_comb begin
                preset_d[g] = preset_q[g];
                if (wr_en && wr_idx == IW'(g)) begin
                    preset_d[g] = clamped;
                end
            end
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    preset_q[g] <= `PSS_PRESET_RESET;
                end else begin
                    preset_q[g] <= preset_d[g];
                end
            end
        end
    endgenerate

    assign rd_data_a = preset_q[rd_idx_a];
    assign rd_data_b = preset_q[rd_idx_b];
endmodule

/* src/pss_selector.sv */
// Purpose: preset speed command selector for the velocity loop
// Assumes: select pins asynchronous; analog word on the same clock
// Notes: register port reads answer one cycle after the read strobe
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "pss_cfg.svh"

module pss_selector #(
    parameter bit HAS_ANALOG = 1'b1
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [`PSS_ADDR_W-1:0] reg_addr,
    input wire logic [`PSS_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`PSS_DATA_W-1:0] reg_rdata,
    input wire logic preset_select_bit0,
    input wire logic preset_select_bit1,
    input wire logic preset_select_bit2,
    input wire logic [`PSS_DATA_W-1:0] analog_speed_channel,
    output logic [`PSS_DATA_W-1:0] speed_command,
    output logic [`PSS_SEL_W-1:0] running_index,
    output logic source_is_analog
);
    // ----------------------------------------
    // select input synchronisers
    // ----------------------------------------
    logic [`PSS_SEL_W-1:0] sel_pins;
    logic [`PSS_SEL_W-1:0] sel_lvl;

    // bit 2 is the most significant select
    assign sel_pins = {preset_select_bit2, preset_select_bit1,
                       preset_select_bit0};

    genvar g;
    generate
        for (g = 0; g < `PSS_SEL_W; g++) begin : g_sync
            // level sampled, no edge detect
            pss_sync3 u_sync (
                .clock(clock),
                .sys_rst(sys_rst),
                .pin(sel_pins[g]),
                .level(sel_lvl[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    pss_pkg::pss_source_t src_q, src_d;
    // the variant has no analog channel, so it may not come up on one
    localparam pss_pkg::pss_source_t SRC_RESET = HAS_ANALOG
        ? pss_pkg::pss_source_t'(`PSS_SOURCE_RESET)
        : pss_pkg::PSS_SRC_PRESET;
    logic pre_wr;
    logic [`PSS_SEL_W-1:0] pre_idx;
    logic [`PSS_SEL_W-1:0] rd_idx;
    logic [`PSS_DATA_W-1:0] pre_cmd, pre_rd;
    logic [`PSS_DATA_W-1:0] rdata_q, rdata_d;

    assign pre_wr = reg_wr && reg_addr >= `PSS_OFS_PRESET_BASE
                    && reg_addr <= `PSS_OFS_PRESET_LAST;
    assign pre_idx = `PSS_SEL_W'(reg_addr - `PSS_OFS_PRESET_BASE);
    assign rd_idx = pre_idx;

    always_comb begin
        src_d = src_q;
        if (reg_wr && reg_addr == `PSS_OFS_SOURCE) begin
            // analog-less variant ignores requests for analog
            if (reg_wdata[0] && HAS_ANALOG) begin
                src_d = pss_pkg::PSS_SRC_ANALOG;
            end else begin
                src_d = pss_pkg::PSS_SRC_PRESET;
            end
        end
    end

    pss_preset_bank u_bank (
        .clock(clock),
        .sys_rst(sys_rst),
        .wr_en(pre_wr),
        .wr_idx(pre_idx),
        .wr_data(reg_wdata),
        .rd_idx_a(sel_lvl),
        .rd_idx_b(rd_idx),
        .rd_data_a(pre_cmd),
        .rd_data_b(pre_rd)
    );

    // ----------------------------------------
    // command selection
    // ----------------------------------------
    logic [`PSS_DATA_W-1:0] cmd_q, cmd_d;
    logic [`PSS_SEL_W-1:0] idx_q, idx_d;

    always_comb begin
        // code n picks preset n; code 0 picks preset 0
        idx_d = sel_lvl;
        if (src_q == pss_pkg::PSS_SRC_ANALOG) begin
            cmd_d = analog_speed_channel;
        end else begin
            cmd_d = pre_cmd;
        end
    end

    always_comb begin
        rdata_d = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                `PSS_OFS_SOURCE: rdata_d = {15'h0000, src_q};
                `PSS_OFS_STATUS: rdata_d = {13'h0000, idx_q};
                `PSS_OFS_COMMAND: rdata_d = cmd_q;
                default: begin
                    if (reg_addr >= `PSS_OFS_PRESET_BASE
                        && reg_addr <= `PSS_OFS_PRESET_LAST) begin
                        rdata_d = pre_rd;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            src_q <= SRC_RESET;
            cmd_q <= `PSS_PRESET_RESET;
            idx_q <= '0;
            rdata_q <= '0;
        end else begin
            src_q <= src_d;
            cmd_q <= cmd_d;
            idx_q <= idx_d;
            rdata_q <= rdata_d;
        end
    end

    assign speed_command = cmd_q;
    assign running_index = idx_q;
    assign source_is_analog = (src_q == pss_pkg::PSS_SRC_ANALOG);
    assign reg_rdata = rdata_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    // these must see reset itself, so they switch the default disable off
    a_reset_outs: assert property (
        disable iff (1'b0)
        sys_rst |=> speed_command == '0 && running_index == '0)
        else $error("outputs not cleared by reset");

    a_reset_read: assert property (
        disable iff (1'b0)
        sys_rst |=> reg_rdata == '0)
        else $error("read data not cleared by reset");

    a_reset_source: assert property (
        disable iff (1'b0)
        sys_rst |=> source_is_analog == HAS_ANALOG)
        else $error("source select came out of reset wrong");

    // ----------------------------------------
    // source select
    // ----------------------------------------
    a_src_write: assert property (
        reg_wr && reg_addr == `PSS_OFS_SOURCE && !reg_wdata[0]
        |=> !source_is_analog)
        else $error("source write to 0 did not select presets");

    a_src_analog: assert property (
        HAS_ANALOG && reg_wr && reg_addr == `PSS_OFS_SOURCE
        && reg_wdata[0] |=> source_is_analog)
        else $error("source write to 1 did not select analog");

    a_src_hold: assert property (
        !(reg_wr && reg_addr == `PSS_OFS_SOURCE)
        |=> $stable(source_is_analog))
        else $error("source select changed without a write");

    a_no_analog: assert property (
        !HAS_ANALOG && reg_wr && reg_addr == `PSS_OFS_SOURCE
        |=> !source_is_analog)
        else $error("analog-less variant took analog source");

    a_variant_preset: assert property (
        !HAS_ANALOG |-> !source_is_analog)
        else $error("analog-less variant left the preset source");

    // ----------------------------------------
    // preset storage and command
    // ----------------------------------------
    a_preset_range: assert property (
        $signed(pre_cmd) <= `PSS_SPEED_MAX
        && $signed(pre_cmd) >= `PSS_SPEED_MIN)
        else $error("stored preset out of range");

    a_cmd_range: assert property (
        !source_is_analog ##1 !source_is_analog
        |-> $signed(speed_command) <= `PSS_SPEED_MAX
        && $signed(speed_command) >= `PSS_SPEED_MIN)
        else $error("preset command out of range");

    // one check per code against the stored word itself, so a fault
    // in the bank's read mux cannot hide behind that same mux
    generate
        for (g = 0; g < `PSS_NUM_PRESETS; g++) begin : g_code_chk
            a_code_map: assert property (
                sel_lvl == `PSS_SEL_W'(g) && !source_is_analog
                |=> speed_command == $past(u_bank.preset_q[g]))
                else $error("select code did not pick its preset");
        end
    endgenerate

    a_zero_code: assert property (
        sel_lvl == '0 && !source_is_analog
        |=> speed_command == $past(u_bank.preset_q[0]))
        else $error("code zero did not give preset 0");

    a_preset_cmd: assert property (
        !source_is_analog |=> speed_command == $past(pre_cmd))
        else $error("preset command late");

    a_analog_cmd: assert property (
        source_is_analog ##1 source_is_analog
        |-> speed_command == $past(analog_speed_channel))
        else $error("analog command late");

    // a write to the preset in use reaches the command two edges on
    a_update_live: assert property (
        pre_wr && pre_idx == sel_lvl && !source_is_analog
        && $signed(reg_wdata) <= `PSS_SPEED_MAX
        && $signed(reg_wdata) >= `PSS_SPEED_MIN
        ##1 $stable(sel_lvl) && !source_is_analog
        |=> speed_command == $past(reg_wdata, 2))
        else $error("preset write did not reach the command");

    // ----------------------------------------
    // select pins
    // ----------------------------------------
    // counts allow for an empty synchroniser right after reset
    a_index_follow: assert property (
        $changed(sel_lvl) |=> running_index == $past(sel_lvl))
        else $error("running index did not follow select");

    a_pin_filter: assert property (
        $stable(sel_pins) [*5] |-> sel_lvl == sel_pins)
        else $error("steady select level not taken");

    a_pin_order: assert property (
        $stable(sel_pins) [*6]
        |-> running_index == {preset_select_bit2, preset_select_bit1,
                              preset_select_bit0})
        else $error("running index bit order wrong");

    // ----------------------------------------
    // read port
    // ----------------------------------------
    // read data is zero outside its answer cycle
    a_read_answer: assert property (
        reg_rd && reg_addr == `PSS_OFS_STATUS
        |=> reg_rdata == {13'h0000, $past(idx_q)})
        else $error("status read wrong");

    a_read_source: assert property (
        reg_rd && reg_addr == `PSS_OFS_SOURCE
        |=> reg_rdata == {15'h0000, $past(source_is_analog)})
        else $error("source read wrong");

    a_read_command: assert property (
        reg_rd && reg_addr == `PSS_OFS_COMMAND
        |=> reg_rdata == $past(speed_command))
        else $error("command read wrong");

    a_read_idle: assert property (
        !reg_rd |=> reg_rdata == '0)
        else $error("read data outside the answer cycle");

    // ----------------------------------------
    // coverage
    // ----------------------------------------
    c_code_seven: cover property (running_index == 3'h7);
    c_analog: cover property (source_is_analog ##1 !source_is_analog);
    c_preset_wr: cover property (pre_wr ##1 reg_rd);
    c_live_write: cover property (pre_wr && pre_idx == sel_lvl);
    c_clamp: cover property (pre_wr && $signed(reg_wdata) > `PSS_SPEED_MAX);
endmodule

/* src/pss_sync3.sv */
// Purpose: three-flop synchroniser with agreement filter for one pin
// Assumes: pin is asynchronous to clock
// Notes: output changes only when stages two and three agree
`timescale 1ns/1ps
module pss_sync3 (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic pin,
    output logic level
);
    logic s1_q, s2_q, s3_q, level_q;
    logic s1_d, s2_d, s3_d, level_d;

    always_comb begin
        s1_d = pin;
        s2_d = s1_q;
        s3_d = s2_q;
        level_d = (s2_q == s3_q) ? s3_q : level_q;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            level_q <= level_d;
        end
    end

    assign level = level_q;
endmodule
